//--- bench/testbench.sv
// Self-checking bench of the converter control block, driven over its AHB-Lite port.
`timescale 1ns/100ps
module testbench;
    import adc_ctrl_pkg::*;
    localparam int CONV = 11;
    localparam int STAB = 4;
    localparam logic [31:0] A_CSR = {22'h0, IDX_CSR, 2'h0};
    localparam logic [31:0] A_HI = {22'h0, IDX_HI, 2'h0};
    localparam logic [31:0] A_LO = {22'h0, IDX_LO, 2'h0};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
    logic done_irq_enable = 1'b0, wait_mode = 1'b0, halt_mode = 1'b0, comparator_high = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
    afe_s afe;
    int vin[16];
    int divs[4] = '{int'(DIV_FAST), int'(DIV_MID), int'(DIV_SLOW), int'(DIV_SLOW)};
    int fails = 0, n_checks = 0, cyc = 0, dt;

    adc_ctrl #(.CONV_CLOCKS(CONV), .STAB_CYCLES(STAB)) adc_ctrl_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .done_irq_enable(done_irq_enable), .wait_mode(wait_mode), .halt_mode(halt_mode),
        .comparator_high(comparator_high), .afe(afe), .irq(irq));

    always #5 hclk = ~hclk;

    // Ideal analog side: the selected input compared with the trial code.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        comparator_high <= (int'(afe.dac_code) <= vin[afe.chan]);
        if (cyc == 40000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single transfer; read data lands in d at the data-phase edge.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask

    function automatic logic [31:0] csrv(input int code, input int on, input int ch);
        return 32'((code << DIVSEL_LSB) | (on << ON_BIT) | ch);
    endfunction

    task automatic await_eoc;
        int t0;
        t0 = cyc;
        d = 32'h0;
        while (d[EOC_BIT] !== 1'b1) bus(1'b0, A_CSR, 32'h0);
        dt = cyc - t0;
    endtask

    task automatic result(input int v);
        bus(1'b0, A_LO, 32'h0);
        chk(d, 32'(v & 3));
        bus(1'b0, A_HI, 32'h0);
        chk(d, 32'(v >> 2));
        bus(1'b0, A_CSR, 32'h0);
        chk(32'(d[EOC_BIT]), 32'h0);
    endtask

    initial begin
        logic [31:0] adr[4];
        int c, v;
        adr = '{A_CSR, A_HI, A_LO, 32'h0};
        void'($urandom(32'hF96FFE09));
        foreach (vin[i]) vin[i] = int'($urandom & 32'h3FF);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (adr[i]) begin
            bus(1'b0, adr[i], 32'h0);
            chk(d, 32'h0);
        end
        bus(1'b1, A_HI, 32'hFF);
        bus(1'b0, A_HI, 32'h0);
        chk(d, 32'h0);
        bus(1'b1, A_CSR, 32'hFFFF_FF8F);
        chk(32'(hresp), 32'h0);
        bus(1'b0, A_CSR, 32'h0);
        chk(d, 32'h0F);
        chk(32'(afe.chan), 32'hF);
        // Every divider code, turned on from off, then one continuous repeat.
        for (int code = 0; code < 4; code++) begin
            c = int'($urandom_range(15, 0));
            bus(1'b1, A_CSR, csrv(code, 1, c));
            await_eoc();
            chk(32'(dt >= (CONV - 1) * divs[code] && dt <= CONV * divs[code] + 8), 32'h1);
            chk(d, 32'h80 | csrv(code, 1, c));
            chk(32'(afe.chan), 32'(c));
            v = vin[c];
            vin[c] = int'($urandom & 32'h3FF);
            result(v);
            await_eoc();
            chk(32'(dt <= CONV * divs[code] + 8), 32'h1);
            result(vin[c]);
            bus(1'b1, A_CSR, csrv(code, 0, c));
            repeat (3) @(posedge hclk);
            chk(32'(afe.powered), 32'h0);
            chk(32'(afe.sampling), 32'h0);
        end
        // Frozen pair while later conversions complete, with wait mode on.
        wait_mode <= 1'b1;
        done_irq_enable <= 1'b1;
        c = 3;
        bus(1'b1, A_CSR, csrv(0, 1, c));
        await_eoc();
        chk(32'(irq), 32'h1);
        v = vin[c];
        vin[c] = int'($urandom & 32'h3FF);
        bus(1'b0, A_LO, 32'h0);
        chk(d, 32'(v & 3));
        repeat (3 * CONV * int'(DIV_FAST)) @(posedge hclk);
        bus(1'b0, A_HI, 32'h0);
        chk(d, 32'(v >> 2));
        await_eoc();
        result(vin[c]);
        chk(32'(irq), 32'h0);
        // Turning off also releases a frozen pair.
        await_eoc();
        bus(1'b0, A_LO, 32'h0);
        vin[c] = int'($urandom & 32'h3FF);
        bus(1'b1, A_CSR, csrv(0, 0, c));
        bus(1'b1, A_CSR, csrv(0, 1, c));
        await_eoc();
        result(vin[c]);
        // Channel change in mid-conversion restarts on the new input and drops the done flag.
        await_eoc();
        repeat (CONV * int'(DIV_FAST) / 2) @(posedge hclk);
        c = c ^ 5;
        bus(1'b1, A_CSR, csrv(0, 1, c));
        bus(1'b0, A_CSR, 32'h0);
        chk(32'(d[EOC_BIT]), 32'h0);
        await_eoc();
        chk(32'(dt >= (CONV - 1) * int'(DIV_FAST) - 4), 32'h1);
        bus(1'b0, A_HI, 32'h0);
        chk(d, 32'(vin[c] >> 2));
        // Halt stops the converter and masks the request; it restarts after settling.
        await_eoc();
        halt_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(32'(irq), 32'h0);
        chk(32'(afe.powered), 32'h0);
        halt_mode <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(32'(afe.powered), 32'h0);
        repeat (STAB + 4) @(posedge hclk);
        chk(32'(afe.powered), 32'h1);
        summarize();
    end
endmodule // testbench

//--- common/adc_ctrl_pkg.sv
// Shared constants, register map and carrier types of the converter control block.
package adc_ctrl_pkg;

    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int F_FAST_HZ = 4_000_000;
    localparam int F_MID_HZ = 2_000_000;
    localparam int F_SLOW_HZ = 1_000_000;
    localparam logic [7:0] DIV_FAST = 8'(CLK_HZ / F_FAST_HZ);
    localparam logic [7:0] DIV_MID = 8'(CLK_HZ / F_MID_HZ);
    localparam logic [7:0] DIV_SLOW = 8'(CLK_HZ / F_SLOW_HZ);
    localparam logic [1:0] SEL_FAST = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_SLOW = 2'h2;

    // Stabilisation time after leaving halt; the figure is a plain default.
    localparam int STAB_NS = 1000;
    localparam int STAB_CYCLES_DEF = (STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_W = 16;

    localparam int RES_W = 10;
    localparam int CHAN_W = 4;
    localparam int CONV_CLOCKS_DEF = 14;
    localparam int HI_LSB = 2;
    localparam int LO_W = 2;

    // Printed register indices; byte address is four times the index.
    localparam int ADDR_LSB = 2;
    localparam logic [7:0] IDX_CSR = 8'h2E;
    localparam logic [7:0] IDX_HI = 8'h2F;
    localparam logic [7:0] IDX_LO = 8'h30;

    localparam int EOC_BIT = 7;
    localparam int DIVSEL_LSB = 5;
    localparam int ON_BIT = 4;
    localparam int CHAN_LSB = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;

    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_CONVERT} sar_state_e;

    typedef struct packed {
        sar_state_e st;
        logic [7:0] cnt;
        logic [3:0] idx;
        logic [RES_W-1:0] code;
        logic [RES_W-1:0] result;
        logic done;
    } sar_s;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic sampling;
        logic [RES_W-1:0] dac_code;
        logic powered;
    } afe_s;

    typedef struct packed {
        logic eoc;
        logic [1:0] div_sel;
        logic on;
        logic [CHAN_W-1:0] chan;
        logic [7:0] res_hi;
        logic [LO_W-1:0] res_lo;
        logic locked;
        logic wr_csr;
        logic [31:0] hrdata;
        logic [7:0] div_cnt;
        logic tick;
        logic [STAB_W-1:0] stab_cnt;
        logic run;
        logic irq;
    } ctrl_s;

endpackage

//--- core/adc_ctrl.sv
// Converter control and result registers behind an AHB-Lite slave port.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module adc_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_CLOCKS = CONV_CLOCKS_DEF,
    parameter int STAB_CYCLES = STAB_CYCLES_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic done_irq_enable,
    input wire logic wait_mode,
    input wire logic halt_mode,
    input wire logic comparator_high,
    output afe_s afe,
    output logic irq
);

    if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << STAB_W)) begin : g_bad_stab
        $error("Stabilisation count does not fit its counter.");
    end

    localparam logic [STAB_W-1:0] STAB_LOAD = STAB_W'(STAB_CYCLES);

    function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] idx);
        reg_hit = (addr[31:ADDR_LSB] == {22'h0, idx});
    endfunction

    function automatic logic [7:0] div_limit(input logic [1:0] sel);
        case (sel)
            SEL_FAST: div_limit = DIV_FAST;
            SEL_MID: div_limit = DIV_MID;
            SEL_SLOW: div_limit = DIV_SLOW;
            default: div_limit = DIV_SLOW;
        endcase
    endfunction

    ctrl_s q;
    ctrl_s d;
    sar_s sar;
    logic take;
    logic rd_csr;
    logic rd_hi;
    logic rd_lo;
    logic restart;
    logic [CHAN_W-1:0] new_chan;
    logic new_on;
    logic load;

    // Every access is taken in its address phase and the slave never inserts waits.
    assign take = hsel & htrans[1] & hready;
    assign rd_csr = take & ~hwrite & reg_hit(haddr, IDX_CSR);
    assign rd_hi = take & ~hwrite & reg_hit(haddr, IDX_HI);
    assign rd_lo = take & ~hwrite & reg_hit(haddr, IDX_LO);
    assign new_chan = hwdata[CHAN_LSB +: CHAN_W];
    assign new_on = hwdata[ON_BIT];
    // A new channel while running, or switching on, starts a fresh conversion.
    assign restart = q.wr_csr & new_on & (~q.on | (new_chan != q.chan));
    // A completion reaches the result pair only while it is not frozen or in the cycle of the high byte read
    // that releases it, and never in the cycle of a low byte read, or the frozen pair would mix two samples.
    assign load = sar.done & ~rd_lo & (~q.locked | rd_hi);

    sar_engine #(
        .CONV_CLOCKS(CONV_CLOCKS)
    ) u_sar (
        .clk(hclk),
        .rst_n(hresetn),
        .tick(q.tick),
        .run(q.run),
        .restart(restart),
        .comparator_high(comparator_high),
        .state(sar)
    );

    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.wr_csr = take & hwrite & reg_hit(haddr, IDX_CSR);

        // Data phase of a control write; the done flag is not writable.
        if (q.wr_csr) begin
            d.div_sel = hwdata[DIVSEL_LSB +: 2];
            d.on = new_on;
            d.chan = new_chan;
        end

        // Wait mode is deliberately not looked at: the converter keeps going.
        d.run = q.on & ~halt_mode & (q.stab_cnt == '0);

        if (halt_mode) begin
            d.stab_cnt = STAB_LOAD;
        end else if (q.stab_cnt != '0) begin
            d.stab_cnt = q.stab_cnt - STAB_W'(1);
        end

        if (!q.run) begin
            d.div_cnt = 8'h00;
        // Greater-or-equal stops a divider change in mid-count from wrapping the counter.
        end else if (q.div_cnt >= div_limit(q.div_sel) - 8'h01) begin
            d.div_cnt = 8'h00;
            d.tick = 1'b1;
        end else begin
            d.div_cnt = q.div_cnt + 8'h01;
        end

        // Clear first so that a completion in the same cycle wins.
        if (rd_hi || restart) begin
            d.eoc = 1'b0;
        end
        if (sar.done) begin
            d.eoc = 1'b1;
        end

        if (rd_lo) begin
            d.locked = 1'b1;
        end
        if (rd_hi || !q.on) begin
            d.locked = 1'b0;
        end

        if (load) begin
            d.res_hi = sar.result[HI_LSB +: 8];
            d.res_lo = sar.result[LO_W-1:0];
        end

        if (take && !hwrite) begin
            if (rd_csr) begin
                d.hrdata = {24'h0, q.eoc, q.div_sel, q.on, q.chan};
            end else if (rd_hi) begin
                d.hrdata = {24'h0, q.res_hi};
            end else if (rd_lo) begin
                d.hrdata = {30'h0, q.res_lo};
            end else begin
                d.hrdata = 32'h0000_0000;
            end
        end

        d.irq = q.eoc & done_irq_enable & ~halt_mode;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{eoc: CSR_RESET[EOC_BIT], div_sel: CSR_RESET[DIVSEL_LSB +: 2],
                   on: CSR_RESET[ON_BIT], chan: CSR_RESET[CHAN_LSB +: CHAN_W],
                   res_hi: RES_RESET, res_lo: RES_RESET[LO_W-1:0], locked: 1'b0,
                   wr_csr: 1'b0, hrdata: 32'h0000_0000, div_cnt: 8'h00, tick: 1'b0,
                   stab_cnt: '0, run: 1'b0, irq: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign irq = q.irq;
    assign afe = '{chan: q.chan, sampling: (sar.st == SAR_SAMPLE), dac_code: sar.code,
                   powered: q.run};

    // Wait mode and the transfer size have no effect; they are gathered here on purpose.
    logic unused_inputs;
    assign unused_inputs = wait_mode ^ (^hsize);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_eoc_set;
        sar.done |=> q.eoc;
    endproperty
    a_eoc_set: assert property (p_eoc_set) else $error("Done flag missed a completion.");

    property p_eoc_readonly;
        q.wr_csr && !sar.done && !restart && !rd_hi |=> q.eoc == $past(q.eoc);
    endproperty
    a_eoc_readonly: assert property (p_eoc_readonly) else $error("Done flag took a write.");

    property p_eoc_clear;
        rd_hi && !sar.done |=> !q.eoc;
    endproperty
    a_eoc_clear: assert property (p_eoc_clear) else $error("High read left done set.");

    property p_restart;
        restart && q.run && !halt_mode && !sar.done |=>
            sar.st == SAR_SAMPLE && sar.cnt == 8'h00 && !q.eoc;
    endproperty
    a_restart: assert property (p_restart) else $error("Channel change did not restart.");

    property p_lock;
        rd_lo && q.on |=> q.locked;
    endproperty
    a_lock: assert property (p_lock) else $error("Low read did not freeze results.");

    property p_unlock;
        rd_hi || !q.on |=> !q.locked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("Results stayed frozen.");

    property p_frozen;
        q.locked && !rd_hi |=> $stable(q.res_hi) && $stable(q.res_lo);
    endproperty
    a_frozen: assert property (p_frozen) else $error("Frozen results changed.");

    property p_off;
        !q.on ##1 !q.on |-> !q.run ##1 sar.st == SAR_IDLE;
    endproperty
    a_off: assert property (p_off) else $error("Converter kept running when off.");

    property p_tick_gap;
        q.tick |=> (!q.tick) [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("Converter clock too fast.");

    property p_chan_out;
        q.wr_csr |=> afe.chan == $past(new_chan);
    endproperty
    a_chan_out: assert property (p_chan_out) else $error("Channel output wrong.");

    property p_low_zero;
        rd_lo |=> hrdata[31:LO_W] == 30'h0 && hrdata[LO_W-1:0] == $past(q.res_lo);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("Low result upper bits not zero.");

    property p_halt;
        halt_mode |=> !q.run ##1 !afe.powered;
    endproperty
    a_halt: assert property (p_halt) else $error("Converter ran in halt.");

    property p_irq;
        q.eoc && done_irq_enable && !halt_mode |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt request missing.");

    property p_hold;
        !sar.done |=> $stable(q.res_hi) && $stable(q.res_lo);
    endproperty
    a_hold: assert property (p_hold) else $error("Result changed without completion.");

    c_done: cover property (sar.done && !q.locked);
    c_locked_done: cover property (q.locked && sar.done);
    c_restart: cover property (restart && q.run);
    c_ten_bit_read: cover property (rd_lo ##[1:4] rd_hi);

endmodule // adc_ctrl

//--- core/sar_engine.sv
// Successive approximation sequencer: sampling phase, bit trials and result.
`timescale 1ns/100ps
module sar_engine
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_CLOCKS = CONV_CLOCKS_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic restart,
    input wire logic comparator_high,
    output sar_s state
);

    localparam int SAMPLE_TICKS = CONV_CLOCKS - RES_W;
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_TICKS - 1);
    localparam logic [3:0] TOP_IDX = 4'(RES_W - 1);

    if (SAMPLE_TICKS < 1 || SAMPLE_TICKS > 256) begin : g_bad_length
        $error("Conversion length must exceed the result width by 1 to 256 clocks.");
    end

    sar_s q;
    sar_s d;
    logic [RES_W-1:0] bit_mask;
    logic [RES_W-1:0] kept;

    always_comb begin
        d = q;
        d.done = 1'b0;
        bit_mask = RES_W'(1) << q.idx;
        kept = comparator_high ? q.code : (q.code & ~bit_mask);
        if (!run) begin
            d.st = SAR_IDLE;
            d.cnt = 8'h00;
            d.code = '0;
        end else if (restart) begin
            d.st = SAR_SAMPLE;
            d.cnt = 8'h00;
            d.code = '0;
        end else begin
            case (q.st)
                SAR_IDLE: begin
                    d.st = SAR_SAMPLE;
                    d.cnt = 8'h00;
                end
                SAR_SAMPLE: begin
                    if (tick) begin
                        if (q.cnt == SAMPLE_LAST) begin
                            d.st = SAR_CONVERT;
                            d.idx = TOP_IDX;
                            d.code = RES_W'(1) << TOP_IDX;
                        end else begin
                            d.cnt = q.cnt + 8'h01;
                        end
                    end
                end
                SAR_CONVERT: begin
                    if (tick) begin
                        if (q.idx == 4'h0) begin
                            d.result = kept;
                            d.done = 1'b1;
                            // Go straight back to sampling: conversion is continuous.
                            d.st = SAR_SAMPLE;
                            d.cnt = 8'h00;
                            d.code = '0;
                        end else begin
                            d.idx = q.idx - 4'h1;
                            d.code = kept | (bit_mask >> 1);
                        end
                    end
                end
                default: begin
                    d.st = SAR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '{st: SAR_IDLE, cnt: 8'h00, idx: 4'h0, code: '0, result: '0, done: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign state = q;

endmodule // sar_engine
